// [design/status_sync.sv]
// Two flip-flop synchroniser bank for asynchronous status levels
`timescale 1ns/100ps
module status_sync #(
  parameter int WIDTH = 3
) (
  // Clock and reset
  input  wire logic      pclk,
  input  wire logic      presetn,
  // Lanes
  status_sync_if.sync    lanes
);

  logic [WIDTH-1:0] stage1_r;
  logic [WIDTH-1:0] stage2_r;

  // First stage feeds only the second stage
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stage1_r <= '0;
      stage2_r <= '0;
    end else begin
      stage1_r <= lanes.raw;
      stage2_r <= stage1_r;
    end
  end

  assign lanes.synced = stage2_r;

endmodule : status_sync

// [design/status_sync_if.sv]
// Raw and synchronised analog status lanes
`timescale 1ns/100ps
interface status_sync_if #(parameter int WIDTH = 3);
  logic [WIDTH-1:0] raw;
  logic [WIDTH-1:0] synced;

  modport sync (input raw, output synced);
  modport user (output raw, input synced);
endinterface : status_sync_if

// [design/usb_phy_common_block_control.sv]
// APB control and status register for the USB PHY common block
//
// How it works
// - Bit 31 set stops the downstream common block clock unless bit 0 is set; clear lets it run.
// - Bit 24 routes functional signals when 0, test signals when 1.
// - Bit 23 picks limited crystal drive at 0, increased drive at 1.
// - Bit 19 picks PLL reference: 0 is 25 MHz at reset, 1 is 24 MHz.
// - Bit 18 reads core supply ready, forced low without high-voltage power-on.
// - Bit 16 enables the USB PLL, read/write, set after reset.
// - Bit 17 set enables fast PLL startup for link power management.
// - Fast-start default from external image, else one-time image, else 0; reloaded on resets.
// - The image entry used depends on high-speed or full-speed operation.
// - Bit 15 low powers down bias and PLL, overriding all transceiver suspends.
// - Bit 14 low powers down the crystal oscillator block.
// - Bit 12 reads 1 when the PLL clocks are usable.
// - Bit 9 set disables the front-end ready timer.
// - Bit 0 set forces every clock gate in the chip into bypass.
`timescale 1ns/100ps
module usb_phy_common_block_control (
  // Clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic             pready,
  output logic [31:0]      prdata,
  output logic             pslverr,
  // Configuration image and USB core state
  input  wire logic        eeprom_present,
  input  wire logic        eeprom_fast_hs,
  input  wire logic        eeprom_fast_fs,
  input  wire logic        otp_configured,
  input  wire logic        otp_fast_hs,
  input  wire logic        otp_fast_fs,
  input  wire logic        hs_mode,
  input  wire logic        usb_reset,
  input  wire logic        light_reset,
  // Analog status, asynchronous
  input  wire logic        core_supply_ready_raw,
  input  wire logic        hv_power_on_raw,
  input  wire logic        pll_clock_good_raw,
  // Local transceiver suspend request
  input  wire logic        local_xcvr_suspend_n,
  // Common block controls
  output logic             common_clk_run,
  output logic             common_test_path_select,
  output logic             crystal_gain_select,
  output logic             pll_reference_freq_select,
  output logic             pll_fast_start_enable,
  output logic             usb_pll_enable,
  output logic             shared_bias_suspend_n,
  output logic             crystal_suspend_n,
  output logic             frontend_ready_timer_off,
  output logic             chip_clock_gate_bypass,
  output logic             afe_powerdown,
  output logic             xcvr_suspend_n
);

  // Storage and bus state
  logic [31:0] ctrl_r;
  logic [31:0] ctrl_nxt;
  logic [31:0] prdata_r;
  logic [31:0] prdata_nxt;
  logic        pslverr_r;
  logic        pslverr_nxt;
  logic        init_r;
  logic        init_nxt;

  // Decode and status
  logic        hit;
  logic        setup_ph;
  logic        wr_en;
  logic [31:0] byte_mask;
  logic [31:0] wmask;
  logic        reload;
  logic        fast_default;
  logic        core_rdy_stat;
  logic        clk_good_stat;
  logic [31:0] read_word;

  status_sync_if #(.WIDTH(usb_phy_common_pkg::SYNC_W)) lanes ();

  // One process drives the whole lane vector, so it has a single driver
  always_comb begin
    lanes.raw = '0;
    lanes.raw[usb_phy_common_pkg::LANE_CORE_RDY] = core_supply_ready_raw;
    lanes.raw[usb_phy_common_pkg::LANE_HV_POR]   = hv_power_on_raw;
    lanes.raw[usb_phy_common_pkg::LANE_CLK_GOOD] = pll_clock_good_raw;
  end

  status_sync #(
    .WIDTH (usb_phy_common_pkg::SYNC_W)
  ) u_sync (
    .pclk    (pclk),
    .presetn (presetn),
    .lanes   (lanes)
  );

  // Status bits are only meaningful once both stages have settled
  assign core_rdy_stat = lanes.synced[usb_phy_common_pkg::LANE_CORE_RDY]
                       & lanes.synced[usb_phy_common_pkg::LANE_HV_POR];
  assign clk_good_stat = lanes.synced[usb_phy_common_pkg::LANE_CLK_GOOD];

  // Fast-start default: external image first, then one-time image, else off
  always_comb begin
    if (eeprom_present) begin
      fast_default = hs_mode ? eeprom_fast_hs : eeprom_fast_fs;
    end else if (otp_configured) begin
      fast_default = hs_mode ? otp_fast_hs : otp_fast_fs;
    end else begin
      fast_default = 1'b0;
    end
  end

  // The first cycle after reset release loads the image value
  assign reload = init_r | usb_reset | light_reset;

  // APB decode; zero wait states, data prepared in the setup cycle
  assign hit       = (paddr[11:2] == usb_phy_common_pkg::CTRL_OFFSET[11:2]);
  assign setup_ph  = psel & ~penable;
  assign wr_en     = psel & penable & pwrite & hit;
  assign pready    = 1'b1;
  assign byte_mask = {{8{pstrb[3]}}, {8{pstrb[2]}}, {8{pstrb[1]}}, {8{pstrb[0]}}};
  assign wmask     = byte_mask & usb_phy_common_pkg::RW_MASK;

  always_comb begin
    read_word = ctrl_r & usb_phy_common_pkg::RW_MASK;
    read_word[usb_phy_common_pkg::CORE_RDY_BIT] = core_rdy_stat;
    read_word[usb_phy_common_pkg::CLK_GOOD_BIT] = clk_good_stat;
  end

  always_comb begin
    ctrl_nxt    = ctrl_r;
    prdata_nxt  = prdata_r;
    pslverr_nxt = pslverr_r;
    init_nxt    = 1'b0;
    if (wr_en) begin
      ctrl_nxt = (ctrl_r & ~wmask) | (pwdata & wmask);
    end
    // A hardware reload wins over a software write in the same cycle
    if (reload) begin
      ctrl_nxt[usb_phy_common_pkg::FAST_START_BIT] = fast_default;
    end
    if (setup_ph) begin
      prdata_nxt  = (hit && !pwrite) ? read_word : 32'h0000_0000;
      pslverr_nxt = ~hit;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_r    <= usb_phy_common_pkg::CTRL_RESET;
      prdata_r  <= 32'h0000_0000;
      pslverr_r <= 1'b0;
      init_r    <= 1'b1;
    end else begin
      ctrl_r    <= ctrl_nxt;
      prdata_r  <= prdata_nxt;
      pslverr_r <= pslverr_nxt;
      init_r    <= init_nxt;
    end
  end

  assign prdata  = prdata_r;
  assign pslverr = pslverr_r & psel & penable;

  // Only the downstream common block clock is gated; this register keeps running
  // so software can always clear the disable again.
  assign common_clk_run = ~ctrl_r[usb_phy_common_pkg::CLK_OFF_BIT]
                        | ctrl_r[usb_phy_common_pkg::GATE_BYPASS_BIT];
  assign common_test_path_select   = ctrl_r[usb_phy_common_pkg::PATH_SEL_BIT];
  assign crystal_gain_select       = ctrl_r[usb_phy_common_pkg::XTAL_GAIN_BIT];
  assign pll_reference_freq_select = ctrl_r[usb_phy_common_pkg::REF_FREQ_BIT];
  assign pll_fast_start_enable     = ctrl_r[usb_phy_common_pkg::FAST_START_BIT];
  assign usb_pll_enable            = ctrl_r[usb_phy_common_pkg::PLL_EN_BIT];
  assign shared_bias_suspend_n     = ctrl_r[usb_phy_common_pkg::BIAS_SUSP_BIT];
  assign crystal_suspend_n         = ctrl_r[usb_phy_common_pkg::XTAL_SUSP_BIT];
  assign frontend_ready_timer_off  = ctrl_r[usb_phy_common_pkg::RDY_TIM_OFF_BIT];
  assign chip_clock_gate_bypass    = ctrl_r[usb_phy_common_pkg::GATE_BYPASS_BIT];
  assign afe_powerdown             = ~ctrl_r[usb_phy_common_pkg::BIAS_SUSP_BIT];
  assign xcvr_suspend_n            = local_xcvr_suspend_n
                                   & ctrl_r[usb_phy_common_pkg::BIAS_SUSP_BIT];

  // Checks
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  logic wr_b3;
  logic wr_b2;
  logic wr_b0;
  logic wr_b1;
  assign wr_b3 = wr_en & pstrb[3];
  assign wr_b2 = wr_en & pstrb[2];
  assign wr_b1 = wr_en & pstrb[1];
  assign wr_b0 = wr_en & pstrb[0];

  clk_gate_off_a: assert property (
    wr_b3 && pwdata[31] && !ctrl_r[0] && !(wr_b0 && pwdata[0]) |=> !common_clk_run)
    else $error("common clock still runs after disable");
  path_select_a: assert property (
    wr_b3 |=> common_test_path_select == $past(pwdata[24]))
    else $error("test path select not updated");
  xtal_gain_a: assert property (
    wr_b2 |=> crystal_gain_select == $past(pwdata[23]))
    else $error("crystal gain select not updated");
  ref_freq_a: assert property (
    wr_b2 |=> pll_reference_freq_select == $past(pwdata[19]))
    else $error("reference frequency select not updated");
  core_ready_a: assert property (
    (!hv_power_on_raw)[*2] |=> !core_rdy_stat ##1 (!(psel && penable && !pwrite && hit)
      || !prdata[usb_phy_common_pkg::CORE_RDY_BIT]))
    else $error("core ready not forced low");
  pll_enable_a: assert property (
    wr_b2 |=> usb_pll_enable == $past(pwdata[16]))
    else $error("pll enable not updated");
  fast_reload_a: assert property (
    usb_reset || light_reset |=> pll_fast_start_enable == $past(fast_default))
    else $error("fast start default not reloaded");
  fast_write_a: assert property (
    wr_b2 && !reload |=> pll_fast_start_enable == $past(pwdata[17]))
    else $error("fast start bit not written");
  bias_override_a: assert property (
    !shared_bias_suspend_n |-> afe_powerdown && !xcvr_suspend_n)
    else $error("local suspend not overridden");
  xtal_susp_a: assert property (
    wr_b1 |=> crystal_suspend_n == $past(pwdata[14]))
    else $error("crystal suspend not updated");
  timer_off_a: assert property (
    wr_b1 |=> frontend_ready_timer_off == $past(pwdata[9]))
    else $error("ready timer disable not updated");
  bypass_a: assert property (
    chip_clock_gate_bypass |-> common_clk_run)
    else $error("bypass did not pass the clock");
  clk_good_a: assert property (
    pll_clock_good_raw [*3] |-> clk_good_stat)
    else $error("clock good status not reported");
  reserved_a: assert property (
    psel && penable && !pwrite && hit |-> (prdata & ~(usb_phy_common_pkg::RW_MASK
      | usb_phy_common_pkg::RO_MASK)) == 32'h0000_0000)
    else $error("reserved bits read nonzero");
  reset_word_a: assert property (
    init_r |-> ctrl_r == usb_phy_common_pkg::CTRL_RESET)
    else $error("register not at reset value");
  init_load_a: assert property (
    init_r ##1 init_r |=> pll_fast_start_enable == $past(fast_default))
    else $error("fast start default not loaded after reset");
  reserved_zero_a: assert property (
    (ctrl_r & ~usb_phy_common_pkg::RW_MASK) == 32'h0000_0000)
    else $error("reserved bit stored");
  core_read_a: assert property (
    psel && penable && !pwrite && hit
      |-> prdata[usb_phy_common_pkg::CORE_RDY_BIT] == $past(core_rdy_stat))
    else $error("core ready read back wrong");
  clk_good_read_a: assert property (
    psel && penable && !pwrite && hit
      |-> prdata[usb_phy_common_pkg::CLK_GOOD_BIT] == $past(clk_good_stat))
    else $error("clock good read back wrong");
  clk_bad_a: assert property (
    (!pll_clock_good_raw) [*3] |-> !clk_good_stat)
    else $error("clock good status stuck high");
  unmapped_err_a: assert property (
    psel && penable && !hit |-> pslverr && prdata == 32'h0000_0000)
    else $error("unmapped access not refused");
  mapped_ok_a: assert property (
    psel && penable && hit |-> !pslverr)
    else $error("mapped access refused");
  write_rd_zero_a: assert property (
    psel && penable && pwrite |-> prdata == 32'h0000_0000)
    else $error("read data not zero during write");
  unmapped_keep_a: assert property (
    psel && penable && pwrite && !hit && !reload |=> ctrl_r == $past(ctrl_r))
    else $error("unmapped write changed the register");
  fast_eep_hs_a: assert property (
    (usb_reset || light_reset) && eeprom_present && hs_mode
      |=> pll_fast_start_enable == $past(eeprom_fast_hs))
    else $error("high-speed external image entry not used");
  fast_eep_fs_a: assert property (
    (usb_reset || light_reset) && eeprom_present && !hs_mode
      |=> pll_fast_start_enable == $past(eeprom_fast_fs))
    else $error("full-speed external image entry not used");
  fast_otp_hs_a: assert property (
    (usb_reset || light_reset) && !eeprom_present && otp_configured && hs_mode
      |=> pll_fast_start_enable == $past(otp_fast_hs))
    else $error("high-speed one-time image entry not used");
  fast_otp_fs_a: assert property (
    (usb_reset || light_reset) && !eeprom_present && otp_configured && !hs_mode
      |=> pll_fast_start_enable == $past(otp_fast_fs))
    else $error("full-speed one-time image entry not used");
  fast_none_a: assert property (
    (usb_reset || light_reset) && !eeprom_present && !otp_configured
      |=> !pll_fast_start_enable)
    else $error("fast start not cleared without an image");
  clk_run_a: assert property (
    wr_b3 && !pwdata[usb_phy_common_pkg::CLK_OFF_BIT] |=> common_clk_run)
    else $error("common clock stopped while enabled");
  bypass_write_a: assert property (
    wr_b0 |=> chip_clock_gate_bypass == $past(pwdata[usb_phy_common_pkg::GATE_BYPASS_BIT]))
    else $error("clock gate bypass not updated");
  bias_write_a: assert property (
    wr_b1 |=> shared_bias_suspend_n == $past(pwdata[usb_phy_common_pkg::BIAS_SUSP_BIT]))
    else $error("common suspend not updated");
  xcvr_pass_a: assert property (
    shared_bias_suspend_n |-> (xcvr_suspend_n == local_xcvr_suspend_n) && !afe_powerdown)
    else $error("local suspend not passed through");

  write_cov_c:  cover property (wr_en ##1 psel && penable && !pwrite && hit);
  reload_cov_c: cover property (usb_reset && fast_default);
  gate_cov_c:   cover property (!common_clk_run ##[1:20] common_clk_run);
  err_cov_c:    cover property (pslverr);
  fast_cov_c:   cover property (light_reset ##1 pll_fast_start_enable);

endmodule : usb_phy_common_block_control

// [design/usb_phy_common_pkg.sv]
// Constants for the USB PHY common block control register
package usb_phy_common_pkg;

  // Register map (byte addresses)
  localparam logic [11:0] CTRL_OFFSET      = 12'h000;
  localparam int          ADDR_W           = 12;

  // Field positions of common_block_test_control
  localparam int          CLK_OFF_BIT      = 31;
  localparam int          PATH_SEL_BIT     = 24;
  localparam int          XTAL_GAIN_BIT    = 23;
  localparam int          REF_FREQ_BIT     = 19;
  localparam int          CORE_RDY_BIT     = 18;
  localparam int          FAST_START_BIT   = 17;
  localparam int          PLL_EN_BIT       = 16;
  localparam int          BIAS_SUSP_BIT    = 15;
  localparam int          XTAL_SUSP_BIT    = 14;
  localparam int          CLK_GOOD_BIT     = 12;
  localparam int          RDY_TIM_OFF_BIT  = 9;
  localparam int          GATE_BYPASS_BIT  = 0;

  // Access masks and reset value
  localparam logic [31:0] RW_MASK          = 32'h818B_C201;
  localparam logic [31:0] RO_MASK          = 32'h0004_1000;
  localparam logic [31:0] CTRL_RESET       = 32'h0001_0000;

  // Status synchroniser lanes
  localparam int          SYNC_W           = 3;
  localparam int          LANE_CORE_RDY    = 0;
  localparam int          LANE_HV_POR      = 1;
  localparam int          LANE_CLK_GOOD    = 2;

endpackage : usb_phy_common_pkg

// [verif/tb.sv]
// Self-checking bench for the USB PHY common block control register
`timescale 1ns/100ps
module tb;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, er;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, m, rd, d;
  logic [3:0]  pstrb;
  logic [6:0]  img;
  logic [2:0]  sts;
  logic        usb_reset, light_reset, lsus, f;
  logic        run, path, gain, rf, fast, pll, bias_n, xtal_n, tmr, byp, afe_pd, xs_n;
  int          mismatches, checked;

  usb_phy_common_block_control i_usb_phy_common_block_control (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .pready(pready), .prdata(prdata),
    .pslverr(pslverr), .eeprom_present(img[6]), .eeprom_fast_hs(img[5]),
    .eeprom_fast_fs(img[4]), .otp_configured(img[3]), .otp_fast_hs(img[2]),
    .otp_fast_fs(img[1]), .hs_mode(img[0]), .usb_reset(usb_reset),
    .light_reset(light_reset), .core_supply_ready_raw(sts[2]), .hv_power_on_raw(sts[1]),
    .pll_clock_good_raw(sts[0]), .local_xcvr_suspend_n(lsus), .common_clk_run(run),
    .common_test_path_select(path), .crystal_gain_select(gain),
    .pll_reference_freq_select(rf), .pll_fast_start_enable(fast), .usb_pll_enable(pll),
    .shared_bias_suspend_n(bias_n), .crystal_suspend_n(xtal_n),
    .frontend_ready_timer_off(tmr), .chip_clock_gate_bypass(byp),
    .afe_powerdown(afe_pd), .xcvr_suspend_n(xs_n));

  // Fast-start default as the image selection picks it
  function automatic logic fdef(input logic [6:0] k);
    return k[6] ? (k[0] ? k[5] : k[4]) : k[3] ? (k[0] ? k[2] : k[1]) : 1'b0;
  endfunction : fdef

  // Read-only bits come from the status lanes, reserved bits read zero
  function automatic logic [31:0] exp_rd(input logic [31:0] r, input logic [2:0] s);
    return (r & usb_phy_common_pkg::RW_MASK) | {13'h0, s[2] & s[1], 5'h0, s[0], 12'h0};
  endfunction : exp_rd

  task automatic end_sim;
    $display("checked=%0d mismatches=%0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : end_sim

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  // One APB transfer; waits on pready with a bounded count
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] wd,
                     input logic [3:0] s, output logic [31:0] r, output logic e);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= wd; pstrb <= s;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) mismatches++;
    r = prdata;
    e = pslverr;
    psel <= 1'b0; penable <= 1'b0;
  endtask : apb

  task automatic wr(input logic [11:0] a, input logic [31:0] wd, input logic [3:0] s);
    logic [31:0] k;
    apb(1'b1, a, wd, s, rd, er);
    k = {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}} & usb_phy_common_pkg::RW_MASK;
    if (a[11:2] == 10'h0) m = (m & ~k) | (wd & k);
  endtask : wr

  task automatic chk_outs;
    @(negedge pclk);
    chk(run, !m[31] | m[0]);
    chk(path, m[24]);
    chk(gain, m[23]);
    chk(rf, m[19]);
    chk(fast, m[17]);
    chk(pll, m[16]);
    chk(bias_n, m[15]);
    chk(afe_pd, !m[15]);
    chk(xs_n, lsus & m[15]);
    chk(xtal_n, m[14]);
    chk(tmr, m[9]);
    chk(byp, m[0]);
    chk(pready, 1'b1);
  endtask : chk_outs

  initial begin
    pclk = 1'b0;
    forever #10 pclk = ~pclk;
  end

  initial begin
    #1ms;
    mismatches++;
    end_sim();
  end

  initial begin
    {psel, penable, pwrite, paddr, pwdata, pstrb, usb_reset, light_reset} = '0;
    img = 7'h00; sts = 3'h0; lsus = 1'b1; presetn = 1'b0;
    m = usb_phy_common_pkg::CTRL_RESET;
    d = $urandom(32'hf0b7);
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    chk_outs();
    apb(1'b0, 12'h000, 32'h0, 4'h0, rd, er);
    chk(rd, usb_phy_common_pkg::CTRL_RESET);
    // Corner words first, then random words and strobes
    for (int i = 0; i < 40; i++) begin
      d = (i == 0) ? 32'hffff_ffff : (i == 1) ? 32'h0000_0000 : $urandom;
      if (i > 1) d[usb_phy_common_pkg::REF_FREQ_BIT] = 1'b0;
      lsus <= 1'($urandom);
      wr({10'h0, 2'($urandom)}, d, (i < 2) ? 4'hf : 4'($urandom));
      chk_outs();
      apb(1'b0, 12'h000, 32'h0, 4'h0, rd, er);
      chk(rd, exp_rd(m, sts));
      chk(er, 1'b0);
    end
    // Unmapped places refuse and leave the register alone
    for (int i = 0; i < 3; i++) begin
      wr(i == 0 ? 12'h004 : i == 1 ? 12'h0c4 : 12'hffc, 32'hffff_ffff, 4'hf);
      chk(er, 1'b1);
      apb(1'b0, 12'h0c4, 32'h0, 4'h0, rd, er);
      chk(rd, 32'h0000_0000);
      chk(er, 1'b1);
    end
    // Status lanes settle after two edges; supply ready gated by power-on
    for (int k = 0; k < 8; k++) begin
      sts <= 3'(k);
      repeat (3) @(posedge pclk);
      apb(1'b0, 12'h000, 32'h0, 4'h0, rd, er);
      chk(rd, exp_rd(m, 3'(k)));
    end
    // Every image selection, reloaded by either reset pulse
    for (int k = 0; k < 128; k++) begin
      @(posedge pclk);
      img <= 7'(k);
      f = fdef(7'(k));
      d = m;
      d[17] = !f;
      wr(12'h000, d, 4'b0100);
      chk_outs();
      @(posedge pclk);
      usb_reset <= k[0] ^ k[3];
      light_reset <= !(k[0] ^ k[3]);
      @(posedge pclk);
      usb_reset <= 1'b0;
      light_reset <= 1'b0;
      m[17] = f;
      @(negedge pclk);
      chk(fast, f);
    end
    // Second reset in mid-run
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    m = usb_phy_common_pkg::CTRL_RESET;
    m[17] = fdef(img);
    repeat (3) @(posedge pclk);
    chk_outs();
    apb(1'b0, 12'h000, 32'h0, 4'h0, rd, er);
    chk(rd, exp_rd(m, sts));
    end_sim();
  end
endmodule : tb
